// >>> inc/rbt_pkg.sv
// Package of constants and types for the eight-bit reload timer.
package rbt_pkg;

    // ========================================================================
    // Register byte offsets on the AXI4-Lite bus.
    // ========================================================================
    localparam logic [3:0] ADDR_MODE = 4'h0;
    localparam logic [3:0] ADDR_COUNT = 4'h4;
    localparam logic [3:0] ADDR_CTRL = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hC;

    // ========================================================================
    // Field positions and reset values.
    // ========================================================================
    localparam int MODE_RELOAD_BIT = 7;
    localparam logic [3:0] MODE_RSVD_ONES = 4'hF;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [2:0] CSEL_RESET = 3'h0;
    localparam logic [2:0] CSEL_EVENT = 3'h7;
    // Control register bits: overflow enable, edge select.
    localparam int CTRL_IE_BIT = 0;
    localparam int CTRL_EDGE_BIT = 1;
    // Status register bit: overflow request flag.
    localparam int STAT_OVF_BIT = 0;

    // ========================================================================
    // Prescaler tap positions (divide by 2**(tap+1)).
    // ========================================================================
    localparam int PRE_WIDTH = 13;
    localparam logic [3:0] TAP_8192 = 4'hC;
    localparam logic [3:0] TAP_2048 = 4'hA;
    localparam logic [3:0] TAP_512 = 4'h8;
    localparam logic [3:0] TAP_256 = 4'h7;
    localparam logic [3:0] TAP_64 = 4'h5;
    localparam logic [3:0] TAP_16 = 4'h3;
    localparam logic [3:0] TAP_4 = 4'h1;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Power states seen by the timer.
    typedef enum logic [2:0]
    {
        PWR_ACTIVE,
        PWR_SLEEP,
        PWR_SUBACTIVE,
        PWR_SUBSLEEP,
        PWR_STANDBY
    } rbt_power_t;

endpackage : rbt_pkg

// >>> test/eight_bit_reload_timer_bench.sv
// Self-checking bench for the eight-bit reload timer.
`timescale 1ns/1ps
module eight_bit_reload_timer_bench
    import rbt_pkg::*;
;
    // ==========
    // Stimulus and observed signals.
    // ==========
    logic I_CLK = 1'b0;
    logic I_RESETN = 1'b0;
    logic [3:0] I_AWADDR = 4'h0;
    logic I_AWVALID = 1'b0;
    logic [31:0] I_WDATA = 32'h0;
    logic I_WVALID = 1'b0;
    logic I_BREADY = 1'b0;
    logic [3:0] I_ARADDR = 4'h0;
    logic I_ARVALID = 1'b0;
    logic I_RREADY = 1'b0;
    logic [2:0] I_POWER_STATE = 3'h0;
    logic pin;
    logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_IRQ;
    logic [1:0] O_BRESP, O_RRESP;
    logic [31:0] O_RDATA;
    int fail_count = 0;
    int tests_run = 0;
    // Free-running 100 MHz clock.
    initial forever #5 I_CLK = ~I_CLK;
    // ==========
    // Design and event source.
    // ==========
    rbt_timer dut (.I_CLK, .I_RESETN, .I_AWADDR, .I_AWVALID, .O_AWREADY,
        .I_WDATA, .I_WSTRB(4'hF), .I_WVALID, .O_WREADY, .O_BRESP, .O_BVALID,
        .I_BREADY, .I_ARADDR, .I_ARVALID, .O_ARREADY, .O_RDATA, .O_RRESP,
        .O_RVALID, .I_RREADY, .I_EVENT_COUNT_INPUT(pin), .I_POWER_STATE,
        .O_IRQ);
    rbt_event_source src (.I_CLK, .o_pin(pin));
    // ==========
    // Checking helpers.
    // ==========
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // A spent wait bound counts as a failure and ends the run.
    task automatic guard(input int k);
        if (k >= 50)
        begin
            fail_count++;
            give_verdict();
        end
    endtask : guard
    // Counter and flag after n pulses from reload r; auto picks reload.
    function automatic logic [8:0] expect_count(logic [7:0] r, logic auto,
        int n);
        logic [7:0] c;
        logic f;
        c = r;
        f = 1'b0;
        repeat (n)
        begin
            f = f | (c == COUNT_MAX);
            c = (c == COUNT_MAX) ? (auto ? r : 8'h00) : c + 8'h01;
        end
        return {f, c};
    endfunction : expect_count
    // ==========
    // Register bus tasks; the answer channel is stalled at random.
    // ==========
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int k;
        logic aw_on;
        logic w_on;
        aw_on = 1'b1;
        w_on = 1'b1;
        I_AWADDR <= a;
        I_WDATA <= d;
        I_AWVALID <= 1'b1;
        I_WVALID <= 1'b1;
        // Local flags track each channel, since the driven valids only
        // settle after this time step.
        for (k = 0; k < 50 && (aw_on || w_on); k++)
        begin
            @(posedge I_CLK);
            if (aw_on && O_AWREADY)
            begin
                I_AWVALID <= 1'b0;
                aw_on = 1'b0;
            end
            if (w_on && O_WREADY)
            begin
                I_WVALID <= 1'b0;
                w_on = 1'b0;
            end
        end
        guard(k);
        repeat ($urandom % 3) @(posedge I_CLK);
        I_BREADY <= 1'b1;
        for (k = 0; k < 50 && !(O_BVALID && I_BREADY); k++)
            @(posedge I_CLK);
        I_BREADY <= 1'b0;
        guard(k);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        int k;
        logic ar_on;
        ar_on = 1'b1;
        I_ARADDR <= a;
        I_ARVALID <= 1'b1;
        for (k = 0; k < 50 && ar_on; k++)
        begin
            @(posedge I_CLK);
            if (O_ARREADY)
            begin
                I_ARVALID <= 1'b0;
                ar_on = 1'b0;
            end
        end
        guard(k);
        repeat ($urandom % 3) @(posedge I_CLK);
        I_RREADY <= 1'b1;
        for (k = 0; k < 50 && !(O_RVALID && I_RREADY); k++)
            @(posedge I_CLK);
        d = O_RDATA;
        I_RREADY <= 1'b0;
        guard(k);
    endtask : rd
    // Hang guard over the whole run.
    initial
    begin
        repeat (100000) @(posedge I_CLK);
        fail_count++;
        give_verdict();
    end
    // ==========
    // Main sequence.
    // ==========
    initial
    begin
        logic [31:0] d;
        logic [31:0] d2;
        logic [8:0] e;
        logic [7:0] r;
        logic b;
        int i;
        int n;
        d = $urandom(37);
        repeat (3) @(posedge I_CLK);
        I_RESETN <= 1'b1;
        rd(ADDR_MODE, d);
        check(d, 32'h78);
        rd(ADDR_COUNT, d);
        check(d, 32'h0);
        // Every clock-select code with a random mode bit reads back.
        for (i = 0; i < 8; i++)
        begin
            b = 1'($urandom % 2);
            wr(ADDR_MODE, {24'h0, b, 4'h0, i[2:0]});
            rd(ADDR_MODE, d);
            check(d, {24'h0, b, 4'hF, i[2:0]});
        end
        // Event counting from random reloads in both modes and edges.
        for (i = 0; i < 8; i++)
        begin
            r = (i == 0) ? 8'hFE : 8'($urandom);
            n = (i == 0) ? 3 : 1 + $urandom % 4;
            wr(ADDR_MODE, {24'h0, i[0], 4'h0, CSEL_EVENT});
            wr(ADDR_CTRL, {30'h0, i[1], 1'b0});
            wr(ADDR_STATUS, 32'h1);
            wr(ADDR_COUNT, {24'h0, r});
            rd(ADDR_COUNT, d);
            check(d, {24'h0, r});
            src.send_pulses(n);
            e = expect_count(r, i[0], n);
            rd(ADDR_COUNT, d);
            check(d, {24'h0, e[7:0]});
            rd(ADDR_STATUS, d);
            check(d, {31'h0, e[8]});
            check({31'h0, O_IRQ}, 32'h0);
        end
        // Flag raised while masked, then unmasked, then cleared.
        wr(ADDR_MODE, {24'h0, 1'b0, 4'h0, CSEL_EVENT});
        wr(ADDR_STATUS, 32'h1);
        wr(ADDR_COUNT, 32'hFF);
        src.send_pulses(1);
        check({31'h0, O_IRQ}, 32'h0);
        wr(ADDR_CTRL, 32'h1);
        repeat (2) @(posedge I_CLK);
        check({31'h0, O_IRQ}, 32'h1);
        wr(ADDR_STATUS, 32'h1);
        repeat (2) @(posedge I_CLK);
        check({31'h0, O_IRQ}, 32'h0);
        rd(ADDR_COUNT, d);
        rd(ADDR_COUNT, d2);
        check(d2, d);
        // Only active and sleep states count; the mode is kept.
        for (i = 1; i < 5; i++)
        begin
            wr(ADDR_COUNT, 32'h10);
            I_POWER_STATE <= i[2:0];
            src.send_pulses(2);
            rd(ADDR_COUNT, d);
            check(d, (i == 1) ? 32'h12 : 32'h10);
            rd(ADDR_MODE, d);
            check(d, 32'h7F);
            I_POWER_STATE <= 3'h0;
        end
        // The divide-by-four source over 42 to 44 cycles between the two
        // sampled reads gives ten or eleven counts.
        wr(ADDR_MODE, 32'h6);
        rd(ADDR_COUNT, d);
        repeat (40) @(posedge I_CLK);
        rd(ADDR_COUNT, d2);
        d2[7:0] = d2[7:0] - d[7:0];
        check({31'h0, d2[7:0] inside {8'h0A, 8'h0B}}, 32'h1);
        give_verdict();
    end
endmodule : eight_bit_reload_timer_bench

// >>> test/rbt_event_source.sv
// Behavioural source of count events on the timer's event pin.
`timescale 1ns/1ps
module rbt_event_source
(
    // Clock and pin.
    input wire logic I_CLK,
    output logic o_pin
);
    // ==========
    // Pulse generator.
    // ==========
    // pin as event input
    // The pin idles low and moves only when the bench has chosen event
    // counting, so it never stands in for a pin interrupt.
    initial o_pin = 1'b0;
    // Pulses are four cycles high and four low, wide enough for the
    // two-flop synchroniser to see each edge once.
    task automatic send_pulses(input int n);
        repeat (n)
        begin
            @(posedge I_CLK);
            o_pin <= 1'b1;
            repeat (4) @(posedge I_CLK);
            o_pin <= 1'b0;
            repeat (3) @(posedge I_CLK);
        end
        // Quiet time lets the last edge reach the counter.
        repeat (8) @(posedge I_CLK);
    endtask : send_pulses
endmodule : rbt_event_source

// >>> test/rbt_timer_properties.sv
// Concurrent checks on the reload timer's bus and interrupt ports.
`timescale 1ns/1ps
module rbt_timer_properties
    import rbt_pkg::*;
(
    // Clock and reset.
    input wire logic I_CLK,
    input wire logic I_RESETN,
    // Write channels.
    input wire logic I_AWVALID,
    input wire logic O_AWREADY,
    input wire logic I_WVALID,
    input wire logic O_WREADY,
    input wire logic [1:0] O_BRESP,
    input wire logic O_BVALID,
    input wire logic I_BREADY,
    // Read channels.
    input wire logic [3:0] I_ARADDR,
    input wire logic I_ARVALID,
    input wire logic O_ARREADY,
    input wire logic [31:0] O_RDATA,
    input wire logic [1:0] O_RRESP,
    input wire logic O_RVALID,
    input wire logic I_RREADY,
    // Interrupt.
    input wire logic O_IRQ
);
    // ==========
    // Clocking and handshake sequences.
    // ==========
    default clocking dc @(posedge I_CLK);
    endclocking
    default disable iff (!I_RESETN);
    // Address and data taken at the same edge.
    sequence write_taken;
        I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
    endsequence
    // An aligned read address taken.
    sequence read_taken;
        I_ARVALID && O_ARREADY && (I_ARADDR[1:0] == 2'h0);
    endsequence
    // ==========
    // Properties.
    // ==========
    // The response follows the held slots by one fire edge.
    property p_write_answer;
        write_taken |-> ##2 O_BVALID;
    endproperty
    // Every aligned offset is mapped, so reads always answer OKAY.
    property p_read_answer;
        read_taken |=> O_RVALID && O_RRESP == RESP_OKAY;
    endproperty
    // A stalled answer keeps its payload.
    property p_bresp_hold;
        O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP);
    endproperty
    property p_rdata_hold;
        O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA);
    endproperty
    property p_upper_zero;
        O_RVALID |-> O_RDATA[31:8] == 24'h0;
    endproperty
    property p_mode_ones;
        read_taken ##0 (I_ARADDR == ADDR_MODE) |=>
            O_RDATA[6:3] == MODE_RSVD_ONES;
    endproperty
    property p_reset_quiet;
        $rose(I_RESETN) |-> !O_IRQ && !O_BVALID && !O_RVALID;
    endproperty
    // Only a status or control write can pull the interrupt down.
    property p_irq_sticky;
        $fell(O_IRQ) |-> $past(O_BVALID) || $past(O_BVALID, 2);
    endproperty
    // ==========
    // Assertions.
    // ==========
    write_answer_a: assert property (p_write_answer)
        else $error("write response not two cycles after request");
    read_answer_a: assert property (p_read_answer)
        else $error("read answer late or refused");
    bresp_hold_a: assert property (p_bresp_hold)
        else $error("write response dropped before taken");
    rdata_hold_a: assert property (p_rdata_hold)
        else $error("read data changed before taken");
    upper_zero_a: assert property (p_upper_zero)
        else $error("read data wider than eight bits");
    mode_ones_a: assert property (p_mode_ones)
        else $error("mode bits six to three not ones");
    reset_quiet_a: assert property (p_reset_quiet)
        else $error("outputs active right after reset");
    irq_sticky_a: assert property (p_irq_sticky)
        else $error("interrupt fell without a register write");
endmodule : rbt_timer_properties

bind rbt_timer rbt_timer_properties chk (.I_CLK, .I_RESETN, .I_AWVALID,
    .O_AWREADY, .I_WVALID, .O_WREADY, .O_BRESP, .O_BVALID, .I_BREADY,
    .I_ARADDR, .I_ARVALID, .O_ARREADY, .O_RDATA, .O_RRESP, .O_RVALID,
    .I_RREADY, .O_IRQ);

// >>> verilog/rbt_count_src.sv
// Count-source selector: prescaler taps or synchronised event edges.
`timescale 1ns/1ps
module rbt_count_src
    import rbt_pkg::*;
(
    // Clock and reset.
    input wire logic I_CLK,
    input wire logic I_RESETN,
    // Selection.
    input wire logic [2:0] i_clock_sel,
    input wire logic i_event_edge_sel,
    input wire logic i_run,
    // Event pin.
    input wire logic i_event_count_input,
    // One-cycle count pulse.
    output logic o_tick
);

    // ========================================================================
    // Prescaler and event synchroniser.
    // ========================================================================
    logic [PRE_WIDTH-1:0] prescale; // Free-running divider.
    logic [PRE_WIDTH-1:0] prescale_d; // Previous divider value.
    logic event_meta; // First synchroniser stage, read only by next.
    logic event_sync; // Second synchroniser stage.
    logic event_prev; // Delayed copy for edge detection.

    // Divider runs always; the sync chain protects against metastability.
    always_ff @(posedge I_CLK)
    begin
        if (!I_RESETN)
        begin
            prescale <= '0;
            prescale_d <= '0;
            event_meta <= 1'b0;
            event_sync <= 1'b0;
            event_prev <= 1'b0;
        end
        else
        begin
            prescale <= prescale + 1'b1;
            prescale_d <= prescale;
            event_meta <= i_event_count_input;
            event_sync <= event_meta;
            event_prev <= event_sync;
        end
    end

    // ========================================================================
    // Tap selection.
    // ========================================================================
    logic [3:0] tap; // Divider bit chosen by the clock select code.
    logic tap_fall; // Falling edge of the chosen divider bit.
    logic ev_rise;
    logic ev_fall;
    logic ev_tick;

    assign tap = (i_clock_sel == 3'h0) ? TAP_8192 :
                 (i_clock_sel == 3'h1) ? TAP_2048 :
                 (i_clock_sel == 3'h2) ? TAP_512 :
                 (i_clock_sel == 3'h3) ? TAP_256 :
                 (i_clock_sel == 3'h4) ? TAP_64 :
                 (i_clock_sel == 3'h5) ? TAP_16 : TAP_4;
    assign tap_fall = prescale_d[tap] & ~prescale[tap];
    assign ev_rise = event_sync & ~event_prev;
    assign ev_fall = ~event_sync & event_prev;
    assign ev_tick = i_event_edge_sel ? ev_rise : ev_fall;

    always_ff @(posedge I_CLK)
    begin
        if (!I_RESETN)
            o_tick <= 1'b0;
        else if (i_clock_sel == CSEL_EVENT)
            o_tick <= i_run & ev_tick;
        else
            o_tick <= i_run & tap_fall;
    end

endmodule : rbt_count_src

// >>> verilog/rbt_timer.sv
// Eight-bit reload timer with an AXI4-Lite register slave.
//
// Notes on behaviour
// - Clock select codes pick seven dividers or event.
// - Mode bit seven: interval or auto-reload.
// - Mode bits six to three read ones.
// - Eight-bit up counter, readable without disturbance.
// - Count past FF sets overflow flag.
// - Counter read and reload write share address.
// - Reload write also loads the counter.
// - Auto-reload mode reloads counter on overflow.
// - Interval mode wraps counter to zero.
// - Reset clears counter, reload and mode bit.
// - Interrupt only when flag and enable set.
// - Event edge select picks rising or falling.
// - Counts only in active and sleep states.
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module rbt_timer
    import rbt_pkg::*;
(
    // Clock and reset.
    input wire logic I_CLK,
    input wire logic I_RESETN,
    // AXI4-Lite write address channel.
    input wire logic [3:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    // AXI4-Lite write data channel.
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    // AXI4-Lite write response channel.
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    // AXI4-Lite read address channel.
    input wire logic [3:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    // AXI4-Lite read data channel.
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    // Pins and system.
    input wire logic I_EVENT_COUNT_INPUT,
    input wire logic [2:0] I_POWER_STATE,
    // Interrupt request.
    output logic O_IRQ
);

    // ========================================================================
    // Register state.
    // ========================================================================
    logic reload_mode_sel; // Auto-reload when high.
    logic [2:0] clock_sel; // Count source code.
    logic [7:0] count_value; // Up counter.
    logic [7:0] reload_value; // Reload register, write only.
    logic overflow_int_enable; // Interrupt mask bit.
    logic event_edge_sel; // High selects rising edges.
    logic overflow_request_flag; // Sticky overflow status.

    // ========================================================================
    // Write channel: address and data may arrive in either order.
    // ========================================================================
    logic aw_held; // Write address captured.
    logic [3:0] aw_addr; // Captured write address.
    logic w_held; // Write data captured.
    logic [31:0] w_data; // Captured write data.
    logic [3:0] w_strb; // Captured byte strobes.
    logic wr_fire; // Both halves present, response free.
    logic wr_hit_mode;
    logic wr_hit_count;
    logic wr_hit_ctrl;
    logic wr_hit_status;
    logic wr_lane0; // Low byte lane enabled.
    logic wr_mapped;

    assign wr_fire = aw_held & w_held & ~O_BVALID;
    assign wr_lane0 = w_strb[0];
    assign wr_hit_mode = wr_fire & wr_lane0 & (aw_addr == ADDR_MODE);
    assign wr_hit_count = wr_fire & wr_lane0 & (aw_addr == ADDR_COUNT);
    assign wr_hit_ctrl = wr_fire & wr_lane0 & (aw_addr == ADDR_CTRL);
    assign wr_hit_status = wr_fire & wr_lane0 & (aw_addr == ADDR_STATUS);
    assign wr_mapped = (aw_addr == ADDR_MODE) | (aw_addr == ADDR_COUNT) |
                       (aw_addr == ADDR_CTRL) | (aw_addr == ADDR_STATUS);

    // Capture the address; ready only while the holding slot is empty.
    always_ff @(posedge I_CLK)
    begin
        if (!I_RESETN)
        begin
            aw_held <= 1'b0;
            aw_addr <= 4'h0;
            O_AWREADY <= 1'b0;
        end
        else if (I_AWVALID & O_AWREADY)
        begin
            aw_held <= 1'b1;
            aw_addr <= {I_AWADDR[3:2], 2'b00};
            O_AWREADY <= 1'b0;
        end
        else if (wr_fire)
        begin
            aw_held <= 1'b0;
            O_AWREADY <= 1'b0;
        end
        else
            O_AWREADY <= ~aw_held & ~O_BVALID;
    end

    // Capture the data the same way.
    always_ff @(posedge I_CLK)
    begin
        if (!I_RESETN)
        begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            O_WREADY <= 1'b0;
        end
        else if (I_WVALID & O_WREADY)
        begin
            w_held <= 1'b1;
            w_data <= I_WDATA;
            w_strb <= I_WSTRB;
            O_WREADY <= 1'b0;
        end
        else if (wr_fire)
        begin
            w_held <= 1'b0;
            O_WREADY <= 1'b0;
        end
        else
            O_WREADY <= ~w_held & ~O_BVALID;
    end

    // Write response, error for unmapped offsets.
    always_ff @(posedge I_CLK)
    begin
        if (!I_RESETN)
        begin
            O_BVALID <= 1'b0;
            O_BRESP <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            O_BVALID <= 1'b1;
            O_BRESP <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (I_BREADY)
            O_BVALID <= 1'b0;
    end

    // ========================================================================
    // Configuration registers.
    // ========================================================================
    // Mode and control bits keep their value in every power state, since
    // only reset and software writes touch them.
    always_ff @(posedge I_CLK)
    begin
        if (!I_RESETN)
        begin
            reload_mode_sel <= 1'b0;
            clock_sel <= CSEL_RESET;
            reload_value <= RELOAD_RESET;
            overflow_int_enable <= 1'b0;
            event_edge_sel <= 1'b0;
        end
        else
        begin
            if (wr_hit_mode)
            begin
                reload_mode_sel <= w_data[MODE_RELOAD_BIT];
                clock_sel <= w_data[2:0];
            end
            if (wr_hit_count)
                reload_value <= w_data[7:0];
            if (wr_hit_ctrl)
            begin
                overflow_int_enable <= w_data[CTRL_IE_BIT];
                event_edge_sel <= w_data[CTRL_EDGE_BIT];
            end
        end
    end

    // ========================================================================
    // Counter core.
    // ========================================================================
    logic count_run; // Power state allows counting.
    logic tick; // One-cycle count pulse.
    logic overflow; // Count pulse while the counter holds FF.
    logic [7:0] wrap_value; // Value taken at overflow.

    assign count_run = (I_POWER_STATE == PWR_ACTIVE) |
                       (I_POWER_STATE == PWR_SLEEP);
    assign overflow = tick & (count_value == COUNT_MAX);
    assign wrap_value = reload_mode_sel ? reload_value : COUNT_RESET;

    rbt_count_src u_count_src
    (
        .I_CLK(I_CLK),
        .I_RESETN(I_RESETN),
        .i_clock_sel(clock_sel),
        .i_event_edge_sel(event_edge_sel),
        .i_run(count_run),
        .i_event_count_input(I_EVENT_COUNT_INPUT),
        .o_tick(tick)
    );

    // A reload write wins over a coincident tick so software sees its value.
    always_ff @(posedge I_CLK)
    begin
        if (!I_RESETN)
            count_value <= COUNT_RESET;
        else if (wr_hit_count)
            count_value <= w_data[7:0];
        else if (overflow)
            count_value <= wrap_value;
        else if (tick)
            count_value <= count_value + 8'h01;
    end

    // ========================================================================
    // Overflow flag and interrupt.
    // ========================================================================
    logic flag_clear; // Software clears by writing one.

    assign flag_clear = wr_hit_status & w_data[STAT_OVF_BIT];

    always_ff @(posedge I_CLK)
    begin
        if (!I_RESETN)
            overflow_request_flag <= 1'b0;
        else if (overflow)
            overflow_request_flag <= 1'b1;
        else if (flag_clear)
            overflow_request_flag <= 1'b0;
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_RESETN)
            O_IRQ <= 1'b0;
        else
            O_IRQ <= overflow_request_flag & overflow_int_enable;
    end

    // ========================================================================
    // Read channel.
    // ========================================================================
    logic [7:0] mode_read; // Mode register image.
    logic [31:0] rd_value; // Data for the decoded address.
    logic rd_mapped;
    logic [3:0] rd_addr;

    assign rd_addr = {I_ARADDR[3:2], 2'b00};
    assign mode_read = {reload_mode_sel, MODE_RSVD_ONES, clock_sel};
    assign rd_mapped = (rd_addr == ADDR_MODE) | (rd_addr == ADDR_COUNT) |
                       (rd_addr == ADDR_CTRL) | (rd_addr == ADDR_STATUS);
    assign rd_value = (rd_addr == ADDR_MODE) ? {24'h0, mode_read} :
                      (rd_addr == ADDR_COUNT) ? {24'h0, count_value} :
                      (rd_addr == ADDR_CTRL) ?
                          {30'h0, event_edge_sel, overflow_int_enable} :
                      (rd_addr == ADDR_STATUS) ?
                          {31'h0, overflow_request_flag} : 32'h0000_0000;

    // Reads take one cycle and have no side effects on the count.
    always_ff @(posedge I_CLK)
    begin
        if (!I_RESETN)
        begin
            O_ARREADY <= 1'b0;
            O_RVALID <= 1'b0;
            O_RDATA <= 32'h0000_0000;
            O_RRESP <= RESP_OKAY;
        end
        else if (I_ARVALID & O_ARREADY)
        begin
            O_ARREADY <= 1'b0;
            O_RVALID <= 1'b1;
            O_RDATA <= rd_value;
            O_RRESP <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (O_RVALID)
        begin
            if (I_RREADY)
                O_RVALID <= 1'b0;
        end
        else
            O_ARREADY <= 1'b1;
    end

endmodule : rbt_timer
